/* core/timer_pkg.sv */
// Shared constants and state types for the dual timer/counter block.
// Assumes a 32-bit AXI4-Lite master; each 8-bit register sits in one aligned word.
package timer_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_CTRL = 10'h088;
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_LOW0 = 10'h08a;
  localparam logic [9:0] IDX_LOW1 = 10'h08b;
  localparam logic [9:0] IDX_HIGH0 = 10'h08c;
  localparam logic [9:0] IDX_HIGH1 = 10'h08d;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h090;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h091;

  // Reset value of every data and control byte.
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Event bit positions in the status, mask, request and acknowledge vectors.
  localparam int EV_TF0 = 0;
  localparam int EV_TF1 = 1;
  localparam int EV_IE0 = 2;
  localparam int EV_IE1 = 3;
  localparam int NUM_EVENTS = 4;

  // Positions of the sampled pins.
  localparam int PIN_CNT0 = 0;
  localparam int PIN_IRQ0 = 2;
  localparam int NUM_PINS = 4;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timer operating modes, in field encoding order 00 to 11.
  typedef enum logic [1:0] {
    MODE_PRESCALED,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } tmr_mode_t;

  // One nibble of the mode register: gate, count source, mode.
  typedef struct packed {
    logic pin_gating;
    logic count_source_sel;
    logic [1:0] mode;
  } tmr_cfg_t;

  // Whole state of the top-level block.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [9:0] waddr;
    logic [7:0] wdata;
    logic wbyte;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic phase;
    logic [1:0] tf;
    logic [1:0] tr;
    logic [1:0] ie;
    logic [1:0] it;
    tmr_cfg_t [1:0] cfg;
    logic [1:0][7:0] tl;
    logic [1:0][7:0] th;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [NUM_EVENTS-1:0] int_req;
    logic irq;
  } core_state_t;

  // State of the pin sampler.
  typedef struct packed {
    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] stable;
    logic [NUM_PINS-1:0] prev;
  } sampler_state_t;

endpackage : timer_pkg

/* core/pin_sampler.sv */
// Two-stage synchroniser with falling-edge detection for the timer pins.
// Assumes pins may change at any time relative to aclk.
`timescale 1ns/1ps
module pin_sampler
  import timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_PINS-1:0] raw_pins,
  output logic [NUM_PINS-1:0] pin_lvl,
  output logic [NUM_PINS-1:0] pin_fall
);

  sampler_state_t st_reg;
  sampler_state_t st_next;

  // The first stage feeds only the second; edges are taken from later stages.
  always_comb begin
    st_next = st_reg;
    st_next.meta = raw_pins;
    st_next.stable = st_reg.meta;
    st_next.prev = st_reg.stable;
  end

  // Synchronous reset returns all stages to low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // A fall is a high sample followed by a low one, so it lasts one cycle.
  assign pin_lvl = st_reg.stable;
  assign pin_fall = st_reg.prev & ~st_reg.stable;

  a_fall_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_fall[0] |=> !pin_fall[0]) else $error("Fall pulse lasted more than one cycle.");

endmodule : pin_sampler

/* core/dual_timer.sv */
// Two timer/counters with external interrupt edge flags, behind AXI4-Lite.
// Assumes the CPU pulses vector_ack when it enters a matching service routine.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Contract
// - Timer 1 overflow sets its flag; vectoring into its routine clears it.
// - Timer 0 overflow sets its flag; vectoring into its routine clears it.
// - Each timer has a run bit: one counts, zero halts.
// - Falling edge on each interrupt pin sets its edge flag; vectoring clears it.
// - Trigger-type bit: zero requests while pin low, one requests on falling edge.
// - Gate bit set: count only while interrupt pin high and run bit set.
// - Source select: timer mode steps every two clocks, counter mode on pin falls.
// - Mode 00: 8-bit high byte with 5-bit low prescaler; 01: 16-bit counter.
// - Mode 10: low byte counts, reloading from high byte on overflow.
// - Timer 0 mode 11: low byte alone; high byte uses timer 1 run and flag.
// - All four data bytes read and write, reset to zero, preloadable.
module dual_timer
  import timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tmr0_count_pin,
  input wire logic tmr1_count_pin,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic [NUM_EVENTS-1:0] vector_ack,
  output logic [NUM_EVENTS-1:0] int_req,
  output logic irq
);

  core_state_t st_reg;
  core_state_t st_next;
  logic [NUM_PINS-1:0] pin_lvl;
  logic [NUM_PINS-1:0] pin_fall;
  logic do_write;
  logic rd_clr;
  logic step;
  logic [1:0] ovf_evt;
  logic [1:0] tf_set;
  logic split_ovf;
  logic [13:0] sum13;
  logic [16:0] sum16;
  logic [8:0] sum8;
  logic [8:0] sum_split;
  logic [9:0] rd_idx;

  // Pins are brought into the clock domain before any counting or flagging.
  pin_sampler u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_pins({ext_irq1_pin, ext_irq0_pin, tmr1_count_pin, tmr0_count_pin}),
    .pin_lvl(pin_lvl),
    .pin_fall(pin_fall)
  );

  // Only indices of real registers answer OKAY.
  function automatic logic reg_mapped(input logic [9:0] idx);
    return (idx >= IDX_CTRL && idx <= IDX_HIGH1) || idx == IDX_IRQ_STATUS ||
      idx == IDX_IRQ_MASK;
  endfunction : reg_mapped

  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // Bus slave, timers, flags and interrupt logic, all as one next-state function.
  always_comb begin
    st_next = st_reg;
    do_write = 1'b0;
    rd_clr = 1'b0;
    step = 1'b0;
    ovf_evt = 2'h0;
    split_ovf = 1'b0;
    sum13 = 14'h0000;
    sum16 = 17'h00000;
    sum8 = 9'h000;
    sum_split = 9'h000;
    // One phase bit gives the divide-by-two timer tick shared by both timers.
    st_next.phase = ~st_reg.phase;

    // Write address and data are taken in either order; the response follows both.
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.awready = 1'b0;
      st_next.waddr = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.wready = 1'b0;
      st_next.wdata = s_axi_wdata[7:0];
      st_next.wbyte = s_axi_wstrb[0];
    end
    if (!st_reg.awready && !st_reg.wready && !st_reg.bvalid) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = reg_mapped(st_reg.waddr) ? RESP_OKAY : RESP_SLVERR;
      do_write = reg_mapped(st_reg.waddr) && st_reg.wbyte;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // Reads answer one cycle after the address; a status read clears it.
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = reg_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      unique case (rd_idx)
        IDX_CTRL: st_next.rdata = {st_reg.tf[1], st_reg.tr[1], st_reg.tf[0], st_reg.tr[0],
          st_reg.ie[1], st_reg.it[1], st_reg.ie[0], st_reg.it[0]};
        IDX_MODE: st_next.rdata = st_reg.cfg;
        IDX_LOW0: st_next.rdata = st_reg.tl[0];
        IDX_LOW1: st_next.rdata = st_reg.tl[1];
        IDX_HIGH0: st_next.rdata = st_reg.th[0];
        IDX_HIGH1: st_next.rdata = st_reg.th[1];
        IDX_IRQ_STATUS: begin
          st_next.rdata = {4'h0, st_reg.irq_status};
          rd_clr = 1'b1;
        end
        IDX_IRQ_MASK: st_next.rdata = {4'h0, st_reg.irq_mask};
        default: st_next.rdata = BYTE_RESET;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end

    // Each timer steps when running, enabled by its gate, and its source ticks.
    for (int i = 0; i < 2; i++) begin
      step = st_reg.tr[i] &&
        (!st_reg.cfg[i].pin_gating || pin_lvl[PIN_IRQ0+i]) &&
        (st_reg.cfg[i].count_source_sel ? pin_fall[PIN_CNT0+i] : st_reg.phase);
      unique case (tmr_mode_t'(st_reg.cfg[i].mode))
        MODE_PRESCALED: begin
          if (step) begin
            // Low five bits prescale; upper low-byte bits are left untouched.
            sum13 = {1'b0, st_reg.th[i], st_reg.tl[i][4:0]} + 14'h0001;
            st_next.th[i] = sum13[12:5];
            st_next.tl[i][4:0] = sum13[4:0];
            ovf_evt[i] = sum13[13];
          end
        end
        MODE_16BIT: begin
          if (step) begin
            sum16 = {1'b0, st_reg.th[i], st_reg.tl[i]} + 17'h00001;
            st_next.th[i] = sum16[15:8];
            st_next.tl[i] = sum16[7:0];
            ovf_evt[i] = sum16[16];
          end
        end
        MODE_RELOAD: begin
          if (step) begin
            sum8 = {1'b0, st_reg.tl[i]} + 9'h001;
            st_next.tl[i] = sum8[8] ? st_reg.th[i] : sum8[7:0];
            ovf_evt[i] = sum8[8];
          end
        end
        MODE_SPLIT: begin
          // Timer 1 holds here; timer 0 keeps only its low byte on its own controls.
          if (step && i == 0) begin
            sum8 = {1'b0, st_reg.tl[i]} + 9'h001;
            st_next.tl[i] = sum8[7:0];
            ovf_evt[i] = sum8[8];
          end
        end
      endcase
    end

    // In split mode the timer 0 high byte borrows timer 1's run bit and flag.
    if (tmr_mode_t'(st_reg.cfg[0].mode) == MODE_SPLIT && st_reg.tr[1] && st_reg.phase) begin
      sum_split = {1'b0, st_reg.th[0]} + 9'h001;
      st_next.th[0] = sum_split[7:0];
      split_ovf = sum_split[8];
    end
    tf_set[0] = ovf_evt[0];
    tf_set[1] = (tmr_mode_t'(st_reg.cfg[0].mode) == MODE_SPLIT) ? split_ovf : ovf_evt[1];

    // Software writes override counting in the same cycle, so a preload is exact.
    if (do_write) begin
      unique case (st_reg.waddr)
        IDX_CTRL: {st_next.tf[1], st_next.tr[1], st_next.tf[0], st_next.tr[0],
          st_next.ie[1], st_next.it[1], st_next.ie[0], st_next.it[0]} = st_reg.wdata;
        IDX_MODE: st_next.cfg = st_reg.wdata;
        IDX_LOW0: st_next.tl[0] = st_reg.wdata;
        IDX_LOW1: st_next.tl[1] = st_reg.wdata;
        IDX_HIGH0: st_next.th[0] = st_reg.wdata;
        IDX_HIGH1: st_next.th[1] = st_reg.wdata;
        IDX_IRQ_MASK: st_next.irq_mask = st_reg.wdata[3:0];
        default: st_next.irq_mask = st_next.irq_mask;
      endcase
    end

    // Vector acknowledge clears a flag, but a set in the same cycle wins.
    st_next.tf = (st_next.tf & ~{vector_ack[EV_TF1], vector_ack[EV_TF0]}) | tf_set;
    st_next.ie = (st_next.ie & ~{vector_ack[EV_IE1], vector_ack[EV_IE0]}) |
      pin_fall[PIN_IRQ0+1:PIN_IRQ0];

    // Sticky status for software; a read clears it unless an event lands meanwhile.
    if (rd_clr) begin
      st_next.irq_status = 4'h0;
    end
    st_next.irq_status = st_next.irq_status | {pin_fall[PIN_IRQ0+1:PIN_IRQ0], tf_set};

    // Level mode requests while the pin is low; edge mode uses the latched flag.
    st_next.int_req[EV_TF0] = st_next.tf[0];
    st_next.int_req[EV_TF1] = st_next.tf[1];
    st_next.int_req[EV_IE0] = st_next.it[0] ? st_next.ie[0] : !pin_lvl[PIN_IRQ0];
    st_next.int_req[EV_IE1] = st_next.it[1] ? st_next.ie[1] : !pin_lvl[PIN_IRQ0+1];
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
  end

  // All state takes its reset value together; ready lines come up high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output is a flip-flop or a constant-extended flip-flop.
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = {24'h000000, st_reg.rdata};
  assign int_req = st_reg.int_req;
  assign irq = st_reg.irq;

  a_tf1_set_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    tf_set[1] |=> st_reg.tf[1] && st_reg.int_req[EV_TF1]) else $error("Timer 1 flag not set.");
  a_tf0_ack_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (vector_ack[EV_TF0] && !tf_set[0] && !do_write) |=> !st_reg.tf[0])
    else $error("Timer 0 flag not cleared by acknowledge.");
  a_run_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_reg.tr[0] && !do_write) |=> $stable(st_reg.tl[0])) else $error("Halted timer moved.");
  a_edge_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_fall[PIN_IRQ0] |=> st_reg.ie[0] && st_reg.irq_status[EV_IE0])
    else $error("Edge flag not set on falling edge.");
  a_level_request: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_next.it[0]) |=> st_reg.int_req[EV_IE0] == !$past(pin_lvl[PIN_IRQ0]))
    else $error("Level request does not follow pin.");
  a_gate_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.cfg[0].pin_gating && !pin_lvl[PIN_IRQ0] && !do_write) |=> $stable(st_reg.tl[0]))
    else $error("Gated timer counted with pin low.");
  a_tick_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.tr[0] && st_reg.cfg[0] == 4'h1 && !do_write)[*2] |=>
    st_reg.tl[0] == 8'($past(st_reg.tl[0], 2) + 8'h01)) else $error("Timer tick rate wrong.");
  a_prescale_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovf_evt[0] && st_reg.cfg[0].mode == 2'h0 && !do_write) |=>
    st_reg.th[0] == 8'h00 && st_reg.tl[0][4:0] == 5'h00) else $error("Prescaled wrap wrong.");
  a_reload_value: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovf_evt[1] && st_reg.cfg[1].mode == 2'h2 && !do_write) |=>
    st_reg.tl[1] == $past(st_reg.th[1])) else $error("Reload value wrong.");
  a_t1_mode3_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.cfg[1].mode == 2'h3 && !do_write) |=> $stable(st_reg.tl[1]) && $stable(st_reg.th[1]))
    else $error("Timer 1 moved in stop mode.");
  a_split_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (split_ovf && st_reg.cfg[0].mode == 2'h3) |=> st_reg.tf[1]) else $error("Split flag missing.");

  // Bus answers stand until taken; a master that stalls must still see the same answer.
  a_bvalid_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.bvalid && !s_axi_bready) |=> st_reg.bvalid && $stable(st_reg.bresp))
    else $error("Write response dropped.");
  a_rvalid_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.rvalid && !s_axi_rready) |=> st_reg.rvalid && $stable(st_reg.rdata))
    else $error("Read data dropped.");
  a_read_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && st_reg.arready) |=> st_reg.rvalid && !st_reg.arready)
    else $error("Read answer late.");
  a_busy_not_ready: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.bvalid |-> !st_reg.awready && !st_reg.wready)
    else $error("Write ready while response pending.");
  a_unmapped_error: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && st_reg.arready && !reg_mapped(rd_idx)) |=>
    st_reg.rresp == RESP_SLVERR && st_reg.rdata == 8'h00)
    else $error("Unmapped read not refused.");

  // Flags reach their request lines; an acknowledge clears unless a set lands with it.
  a_tf0_set_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    tf_set[0] |=> st_reg.tf[0] && st_reg.int_req[EV_TF0]) else $error("Timer 0 flag not set.");
  a_tf1_ack_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (vector_ack[EV_TF1] && !tf_set[1] && !do_write) |=> !st_reg.tf[1])
    else $error("Timer 1 flag not cleared.");
  a_edge1_ack_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (vector_ack[EV_IE1] && !pin_fall[PIN_IRQ0+1] && !do_write) |=> !st_reg.ie[1])
    else $error("Edge flag 1 not cleared.");
  a_edge_request: assert property (@(posedge aclk) disable iff (!aresetn)
    st_next.it[1] |=> st_reg.int_req[EV_IE1] == st_reg.ie[1])
    else $error("Edge request does not follow flag.");

  // Status bits stay until read, so software never loses an event between polls.
  a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.irq_status[EV_TF0] && !rd_clr) |=> st_reg.irq_status[EV_TF0])
    else $error("Status bit lost.");
  a_status_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_clr && !tf_set[0]) |=> !st_reg.irq_status[EV_TF0])
    else $error("Status read did not clear.");

  // Counting seen from the timer 1 side, plus the full 16-bit wrap of timer 0.
  a_t1_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_reg.tr[1] && !do_write) |=> $stable(st_reg.tl[1]) && $stable(st_reg.th[1]))
    else $error("Halted timer 1 moved.");
  a_t1_pin_source: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.cfg[1].count_source_sel && !pin_fall[PIN_CNT0+1] && !do_write) |=>
    $stable(st_reg.tl[1])) else $error("Counted without pin fall.");
  a_sixteen_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovf_evt[0] && st_reg.cfg[0].mode == 2'h1 && !do_write) |=>
    st_reg.th[0] == 8'h00 && st_reg.tl[0] == 8'h00) else $error("16-bit wrap wrong.");
  a_reload_keeps_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovf_evt[1] && st_reg.cfg[1].mode == 2'h2 && !do_write) |=> $stable(st_reg.th[1]))
    else $error("Reload source changed.");
  a_t1_stop_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.cfg[1].mode == 2'h3 && st_reg.cfg[0].mode != 2'h3) |-> !tf_set[1])
    else $error("Stopped timer 1 flagged.");
  a_split_high_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.cfg[0].mode == 2'h3 && !st_reg.tr[1] && !do_write) |=> $stable(st_reg.th[0]))
    else $error("Split high byte moved.");
  a_write_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && st_reg.waddr == IDX_LOW1) |=> st_reg.tl[1] == $past(st_reg.wdata))
    else $error("Data write did not land.");
  a_fall_from_high: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_fall[PIN_CNT0+1] |-> !pin_lvl[PIN_CNT0+1] && $past(pin_lvl[PIN_CNT0+1]))
    else $error("Fall without prior high.");

endmodule : dual_timer

/* testbench/pin_cpu_model.sv */
// Far-side model: count and interrupt pins plus the CPU vector acknowledge.
// Assumes its tasks are called from just after a rising edge of aclk.
`timescale 1ns/1ps
module pin_cpu_model (
  input wire logic aclk,
  output logic tmr0_count_pin,
  output logic tmr1_count_pin,
  output logic ext_irq0_pin,
  output logic ext_irq1_pin,
  output logic [3:0] vector_ack
);
  logic [3:0] lvl = 4'hf;
  initial vector_ack = 4'h0;
  // Pins idle high, as a pulled-up input would.
  assign {ext_irq1_pin, ext_irq0_pin, tmr1_count_pin, tmr0_count_pin} = lvl;
  // Each level stands four clocks, so the two-flop synchroniser never misses it.
  task automatic set_pin(input int k, input logic v);
    lvl[k] <= v;
    repeat (4) @(posedge aclk);
  endtask : set_pin
  // One falling edge followed by a return to the idle level.
  task automatic fall(input int k);
    set_pin(k, 1'b0);
    set_pin(k, 1'b1);
  endtask : fall
  // One-cycle pulse as the CPU enters the matching routine.
  task automatic ack(input int k);
    vector_ack[k] <= 1'b1;
    @(posedge aclk);
    vector_ack[k] <= 1'b0;
    @(posedge aclk);
  endtask : ack
endmodule : pin_cpu_model

/* testbench/dual_timer_counter_ext_irq_tb.sv */
// Self-checking bench for the dual timer block over AXI4-Lite.
// Assumes the pin and vector model above stands on the far side.
`timescale 1ns/1ps
module dual_timer_counter_ext_irq_tb;
  import timer_pkg::*;
  localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_MODE = {IDX_MODE, 2'b00};
  localparam logic [11:0] A_L0 = {IDX_LOW0, 2'b00};
  localparam logic [11:0] A_L1 = {IDX_LOW1, 2'b00};
  localparam logic [11:0] A_H0 = {IDX_HIGH0, 2'b00};
  localparam logic [11:0] A_H1 = {IDX_HIGH1, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] r;
  } row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata;
  logic tmr0_count_pin, tmr1_count_pin, ext_irq0_pin, ext_irq1_pin;
  logic [3:0] vector_ack, int_req;
  logic [7:0] rv, rv2;
  int num_errors = 0;
  int compares = 0;
  int n;
  row_t rows [7] = '{'{A_L0, 8'ha5, 8'ha5, RESP_OKAY}, '{A_L1, 8'h5a, 8'h5a, RESP_OKAY},
    '{A_H0, 8'h3c, 8'h3c, RESP_OKAY}, '{A_H1, 8'hc3, 8'hc3, RESP_OKAY},
    '{A_MODE, 8'ha5, 8'ha5, RESP_OKAY}, '{A_MASK + 12'h003, 8'h0f, 8'h0f, RESP_OKAY},
    '{12'h300, 8'h77, 8'h00, RESP_SLVERR}};
  logic [11:0] regs [6] = '{A_CTRL, A_MODE, A_L0, A_L1, A_H0, A_H1};

  dual_timer i_dual_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tmr0_count_pin,
    .tmr1_count_pin, .ext_irq0_pin, .ext_irq1_pin, .vector_ack, .int_req, .irq);
  pin_cpu_model i_pin_cpu_model (.aclk, .tmr0_count_pin, .tmr1_count_pin, .ext_irq0_pin,
    .ext_irq1_pin, .vector_ack);

  // Clock at 200 MHz.
  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Write with address and data offered together; each drops once taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int k;
    logic got;
    k = 0;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {{3{~d}}, d}; // Upper lanes carry junk that must be ignored.
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && k < 50) begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        got = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
    if (!got) chk(8'h01, 8'h00);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    int k;
    logic got;
    k = 0;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && k < 50) begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        got = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got) chk(8'h02, 8'h00);
  endtask : rd

  // Bounded wait for one request line; c returns the clocks spent.
  task automatic wait_req(input int b, output int c);
    c = 0;
    while (int_req[b] !== 1'b1 && c < 100) begin
      @(posedge aclk);
      c++;
    end
  endtask : wait_req

  // The hang limit of 10000 clocks is far beyond the few hundred clocks the tests need.
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end

  // Main sequence: reset, table rows, then the timing and flag cases.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(irq, 1'b0);
    foreach (regs[i]) begin
      rd(regs[i], rv, rs);
      chk(rv, BYTE_RESET);
      chk(rs, RESP_OKAY);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rs);
      chk(rs, rows[i].r);
      rd(rows[i].a, rv, rs);
      chk(rv, rows[i].q);
      chk(rs, rows[i].r);
    end
    // A write with byte lane 0 off answers OKAY but stores nothing.
    s_axi_wstrb <= 4'he;
    wr(A_L1, 8'h33, rs);
    chk(rs, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(A_L1, rv, rs);
    chk(rv, 8'h5a);
    // Sixteen timer steps from f0 to the wrap take about 32 clocks.
    wr(A_MODE, 8'h01, rs);
    wr(A_L0, 8'hf0, rs);
    wr(A_H0, 8'hff, rs);
    wr(A_CTRL, 8'h10, rs);
    wait_req(0, n);
    chk(n >= 30 && n <= 36, 1'b1);
    rd(A_STAT, rv, rs);
    chk(rv, 8'h01);
    rd(A_STAT, rv, rs);
    chk(rv, 8'h00);
    i_pin_cpu_model.ack(0);
    chk(int_req[0], 1'b0);
    wr(A_CTRL, 8'h00, rs);
    rd(A_L0, rv, rs);
    repeat (20) @(posedge aclk);
    rd(A_L0, rv2, rs);
    chk(rv2, rv);
    // Prescaled mode in counter form: one pin fall wraps both parts.
    wr(A_MODE, 8'h04, rs);
    wr(A_L0, 8'hff, rs);
    wr(A_H0, 8'hff, rs);
    wr(A_MASK, 8'h01, rs);
    wr(A_CTRL, 8'h10, rs);
    i_pin_cpu_model.fall(0);
    rd(A_L0, rv, rs);
    chk(rv, 8'he0);
    rd(A_H0, rv, rs);
    chk(rv, 8'h00);
    chk({int_req[0], irq}, 2'b11);
    rd(A_STAT, rv, rs);
    chk(irq, 1'b0);
    // Timer 1 auto-reload, then its stopped mode.
    wr(A_MODE, 8'h60, rs);
    wr(A_L1, 8'hff, rs);
    wr(A_H1, 8'h80, rs);
    wr(A_CTRL, 8'h40, rs);
    i_pin_cpu_model.fall(1);
    rd(A_L1, rv, rs);
    chk(rv, 8'h80);
    chk(int_req[1], 1'b1);
    i_pin_cpu_model.ack(1);
    chk(int_req[1], 1'b0);
    i_pin_cpu_model.fall(1);
    rd(A_L1, rv, rs);
    chk(rv, 8'h81);
    wr(A_MODE, 8'h70, rs);
    i_pin_cpu_model.fall(1);
    rd(A_L1, rv, rs);
    chk(rv, 8'h81);
    // Gated counter: the low interrupt pin blocks counting and requests by level.
    wr(A_MODE, 8'h0d, rs);
    wr(A_L0, 8'h00, rs);
    wr(A_CTRL, 8'h10, rs);
    i_pin_cpu_model.set_pin(2, 1'b0);
    i_pin_cpu_model.fall(0);
    rd(A_L0, rv, rs);
    chk(rv, 8'h00);
    chk(int_req[2], 1'b1);
    i_pin_cpu_model.set_pin(2, 1'b1);
    i_pin_cpu_model.fall(0);
    rd(A_L0, rv, rs);
    chk(rv, 8'h01);
    chk(int_req[2], 1'b0);
    // Edge-triggered requests on both inputs, cleared by vectoring.
    for (int k = 0; k < 2; k++) begin
      wr(A_CTRL, 8'h05, rs);
      chk(int_req[2+k], 1'b0);
      i_pin_cpu_model.fall(2 + k);
      chk(int_req[2+k], 1'b1);
      rd(A_CTRL, rv, rs);
      chk(rv[1+2*k], 1'b1);
      i_pin_cpu_model.ack(2 + k);
      chk(int_req[2+k], 1'b0);
    end
    // Split mode: low byte on pin falls, high byte on ticks under the timer 1 run bit.
    wr(A_MODE, 8'h07, rs);
    wr(A_L0, 8'h10, rs);
    wr(A_H0, 8'hf0, rs);
    wr(A_CTRL, 8'h50, rs);
    i_pin_cpu_model.fall(0);
    rd(A_L0, rv, rs);
    chk(rv, 8'h11);
    wait_req(1, n);
    chk(n < 40, 1'b1);
    complete_run();
  end
endmodule : dual_timer_counter_ext_irq_tb
